//--- icu_pkg.sv
package icu_pkg;
  // =====================================================
  // Register map
  localparam logic [3:0] ICU_OFF_CON1 = 4'h0;
  localparam logic [3:0] ICU_OFF_CON2 = 4'h4;
  localparam logic [3:0] ICU_OFF_FIFO = 4'h8;
  localparam logic [3:0] ICU_OFF_CNT = 4'hC;
  // =====================================================
  // Control one fields
  localparam int ICU_C1_MODE_LO = 0;
  localparam int ICU_C1_BNE = 3;
  localparam int ICU_C1_OV = 4;
  localparam int ICU_C1_RATE_LO = 5;
  localparam int ICU_C1_IDLE = 13;
  localparam int ICU_C1_TSEL_LO = 10;
  localparam logic [15:0] ICU_C1_WMASK = 16'h3C67;
  // =====================================================
  // Control two fields
  localparam int ICU_C2_SYNC_LO = 0;
  localparam int ICU_C2_TSTAT = 6;
  localparam int ICU_C2_TRIG = 7;
  localparam int ICU_C2_CASC = 8;
  localparam logic [15:0] ICU_C2_WMASK = 16'h01DF;
  localparam logic [15:0] ICU_C2_RESET = 16'h000D;
  // =====================================================
  // Codes
  localparam logic [4:0] ICU_SYNC_NONE = 5'h00;
  localparam logic [2:0] ICU_TSEL_SYS = 3'h7;
  localparam logic [2:0] ICU_DIS = 3'h0;
  localparam logic [2:0] ICU_BOTH = 3'h1;
  localparam logic [2:0] ICU_FALL = 3'h2;
  localparam logic [2:0] ICU_RISE = 3'h3;
  localparam logic [2:0] ICU_RISE4 = 3'h4;
  localparam logic [2:0] ICU_RISE16 = 3'h5;
  localparam logic [2:0] ICU_WAKE = 3'h7;
  localparam logic [3:0] ICU_PRE4 = 4'h3;
  localparam logic [3:0] ICU_PRE16 = 4'hF;
  localparam int ICU_DEPTH = 4;
  typedef enum logic [1:0] {
    ICU_FREE = 2'b00,
    ICU_SYNC = 2'b01,
    ICU_HTRIG = 2'b10,
    ICU_STRIG = 2'b11
  } icu_op_t;
endpackage

//--- icu_sync.sv
`timescale 1ns/1ns
module icu_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Level
  input wire logic d,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

//--- icu_fifo.sv
`timescale 1ns/1ns
module icu_fifo (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Push side
  input wire logic push,
  input wire logic [15:0] push_data,
  output logic full,
  // Pop side
  input wire logic pop,
  output logic [15:0] head,
  output logic not_empty
);
  import icu_pkg::*;
  logic [15:0] mem [ICU_DEPTH];
  logic [1:0] wr_reg;
  logic [1:0] rd_reg;
  logic [2:0] cnt_reg;
  logic do_push;
  logic do_pop;
  assign full = (cnt_reg == 3'(ICU_DEPTH));
  assign not_empty = (cnt_reg != 3'h0);
  assign do_push = push && !full;
  assign do_pop = pop && not_empty;
  assign head = mem[rd_reg];
  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_reg] <= push_data;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= 2'h0;
      rd_reg <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 2'h1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 2'h1;
      end
      cnt_reg <= cnt_reg + 3'(do_push) - 3'(do_pop);
    end
  end
endmodule

//--- icu_capture.sv
`timescale 1ns/1ns
module icu_capture (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture pin and system sources
  input wire logic capture_input_pin,
  input wire logic [7:0] time_base_ticks,
  input wire logic [31:0] sync_events,
  input wire logic sync_source_enabled,
  input wire logic low_power,
  // Cascade link to paired channel
  input wire logic is_high_channel,
  input wire logic peer_cascade_enable,
  input wire logic peer_wrap,
  input wire logic peer_run,
  output logic cascade_enable,
  output logic wrap_out,
  output logic run_out,
  // Events
  output logic capture_irq,
  output logic wake_irq
);
  import icu_pkg::*;

  // =====================================================
  // Registers and decode
  logic [15:0] con1_reg;
  logic [15:0] con2_reg;
  logic [15:0] capture_counter;
  logic pin_s;
  logic pin_d_reg;
  logic [2:0] mode;
  logic [1:0] rate;
  logic [2:0] tsel;
  logic [4:0] sync_source_select;
  logic trigger_select;
  logic trigger_status;
  logic cascaded;
  logic tick;
  logic sync_evt;
  logic rise;
  logic fall;
  logic edge_ok;
  logic capture_evt;
  logic fifo_full;
  logic buffer_not_empty;
  logic capture_overflow;
  logic [15:0] fifo_head;
  logic fifo_pop;
  logic [3:0] pre_reg;
  logic [1:0] irq_cnt_reg;
  logic running;
  logic hold_reset;
  icu_op_t op;
  logic wr;
  logic rd;

  function automatic icu_op_t op_decode(input logic [4:0] src, input logic trg);
    if (src == ICU_SYNC_NONE) begin
      op_decode = trg ? ICU_STRIG : ICU_FREE;
    end else begin
      op_decode = trg ? ICU_HTRIG : ICU_SYNC;
    end
  endfunction

  assign mode = con1_reg[ICU_C1_MODE_LO +: 3];
  assign rate = con1_reg[ICU_C1_RATE_LO +: 2];
  assign tsel = con1_reg[ICU_C1_TSEL_LO +: 3];
  assign sync_source_select = con2_reg[ICU_C2_SYNC_LO +: 5];
  assign trigger_select = con2_reg[ICU_C2_TRIG];
  assign trigger_status = con2_reg[ICU_C2_TSTAT];
  assign cascade_enable = con2_reg[ICU_C2_CASC];
  assign cascaded = cascade_enable && peer_cascade_enable;
  // Mode decode; cascaded high channel forced synchronous.
  assign op = (cascaded && is_high_channel) ? ICU_SYNC
            : op_decode(sync_source_select, trigger_select);
  assign tick = time_base_ticks[tsel];
  assign sync_evt = sync_events[sync_source_select];
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign fifo_pop = rd && (paddr == ICU_OFF_FIFO);

  // =====================================================
  // Pin synchroniser and edge detect
  icu_sync u_pin (
    .clock(clock),
    .rstn(rstn),
    .d(capture_input_pin),
    .q(pin_s)
  );
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_d_reg <= 1'b0;
    end else begin
      pin_d_reg <= pin_s;
    end
  end
  assign rise = pin_s && !pin_d_reg;
  assign fall = !pin_s && pin_d_reg;

  // =====================================================
  // Run control
  // Cascaded sync held in reset until source enabled.
  assign hold_reset = cascaded && (op == ICU_SYNC) && !sync_source_enabled;
  // Triggered modes run only after trigger status.
  assign running = (cascaded && is_high_channel) ? peer_run
                 : (((op == ICU_HTRIG) || (op == ICU_STRIG)) ? trigger_status : 1'b1)
                   && !hold_reset;
  assign run_out = running;

  // =====================================================
  // Capture counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      capture_counter <= 16'h0000;
    end else if (hold_reset || mode == ICU_DIS) begin
      capture_counter <= 16'h0000;
    end else if (op == ICU_SYNC && sync_evt && !is_high_channel) begin
      capture_counter <= 16'h0000;
    end else if (cascaded && is_high_channel) begin
      if (peer_wrap) begin
        capture_counter <= capture_counter + 16'h0001;
      end
    end else if (running && tick) begin
      capture_counter <= capture_counter + 16'h0001;
    end
  end
  assign wrap_out = running && tick && (capture_counter == 16'hFFFF) && !hold_reset;

  // =====================================================
  // Edge qualification
  // Mode decode; both edges, falling, rising, every 4th or every 16th rise.
  always_comb begin
    case (mode)
      ICU_BOTH: edge_ok = rise || fall;
      ICU_FALL: edge_ok = fall;
      ICU_RISE: edge_ok = rise;
      ICU_RISE4: edge_ok = rise && (pre_reg[1:0] == ICU_PRE4[1:0]);
      ICU_RISE16: edge_ok = rise && (pre_reg == ICU_PRE16);
      default: edge_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= 4'h0;
    end else if (mode != ICU_RISE4 && mode != ICU_RISE16) begin
      pre_reg <= 4'h0;
    end else if (rise) begin
      pre_reg <= (mode == ICU_RISE4 && pre_reg[1:0] == ICU_PRE4[1:0]) ? 4'h0 : pre_reg + 4'h1;
    end
  end
  assign capture_evt = edge_ok && running;
  assign wake_irq = (mode == ICU_WAKE) && low_power && rise;

  // =====================================================
  // FIFO
  // Four deep; push counter.
  icu_fifo u_fifo (
    .clock(clock),
    .rstn(rstn),
    .push(capture_evt),
    .push_data(capture_counter),
    .full(fifo_full),
    .pop(fifo_pop),
    .head(fifo_head),
    .not_empty(buffer_not_empty)
  );

  // Overflow set on drop, set wins over read clear.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      capture_overflow <= 1'b0;
    end else if (capture_evt && fifo_full) begin
      capture_overflow <= 1'b1;
    end else if (fifo_pop) begin
      capture_overflow <= 1'b0;
    end
  end

  // =====================================================
  // Interrupt rate
  // Every rate+1 captures; mode one ignores rate.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_cnt_reg <= 2'h0;
      capture_irq <= 1'b0;
    end else if (mode == ICU_DIS) begin
      // A disabled channel forgets partial interrupt counts.
      irq_cnt_reg <= 2'h0;
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= 1'b0;
      if (capture_evt && !fifo_full) begin
        if (mode == ICU_BOTH || irq_cnt_reg == rate) begin
          irq_cnt_reg <= 2'h0;
          capture_irq <= 1'b1;
        end else begin
          irq_cnt_reg <= irq_cnt_reg + 2'h1;
        end
      end
    end
  end

  // =====================================================
  // Control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      con1_reg <= 16'h0000;
    end else if (wr && paddr == ICU_OFF_CON1) begin
      con1_reg <= pwdata[15:0] & ICU_C1_WMASK;
    end
  end
  // Software sets status; hardware sets it on trigger.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      con2_reg <= ICU_C2_RESET;
    end else begin
      if (wr && paddr == ICU_OFF_CON2) begin
        con2_reg <= pwdata[15:0] & ICU_C2_WMASK;
      end
      if (op == ICU_HTRIG && sync_evt) begin
        con2_reg[ICU_C2_TSTAT] <= 1'b1;
      end
    end
  end

  // =====================================================
  // APB read
  // Not-empty; overflow read-only.
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      ICU_OFF_CON1: begin
        prdata[15:0] = con1_reg;
        prdata[ICU_C1_OV] = capture_overflow;
        prdata[ICU_C1_BNE] = buffer_not_empty;
      end
      ICU_OFF_CON2: prdata[15:0] = con2_reg;
      ICU_OFF_FIFO: prdata[15:0] = fifo_head;
      ICU_OFF_CNT: prdata[15:0] = capture_counter;
      default: prdata = 32'h0000_0000;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr[1:0] != 2'b00);
endmodule

//--- icu_capture_properties.sv
`timescale 1ns/1ns
module icu_capture_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel
  input wire logic low_power,
  input wire logic is_high_channel,
  input wire logic cascade_enable,
  input wire logic run_out,
  input wire logic capture_irq,
  input wire logic wake_irq
);
  import icu_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ========
  // Checks.
  a_no_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_err_align: assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  a_casc_bit: assert property (psel && penable && pwrite && paddr == ICU_OFF_CON2
    |=> cascade_enable == $past(pwdata[ICU_C2_CASC]))
    else $error("cascade enable not written");
  a_hold_trig: assert property (psel && paddr == ICU_OFF_CON2 && prdata[7:6] == 2'h2
    && !is_high_channel |-> !run_out)
    else $error("counter runs before trigger");
  a_wake_lp: assert property (wake_irq |-> low_power)
    else $error("wake event while awake");
  a_irq_pulse: assert property (capture_irq |=> !capture_irq)
    else $error("capture interrupt longer than one cycle");
  a_irq_bne: assert property (capture_irq && psel && paddr == ICU_OFF_CON1
    |-> prdata[ICU_C1_BNE])
    else $error("interrupt with empty buffer flag");
  c_irq: cover property (capture_irq);
  c_wake: cover property (wake_irq);
  c_err: cover property (pslverr);
endmodule
bind icu_capture icu_capture_properties u_props (
  .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .low_power, .is_high_channel, .cascade_enable, .run_out, .capture_irq, .wake_irq
);

//--- icu_pulse_src.sv
`timescale 1ns/1ns
module icu_pulse_src (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Command
  input wire logic go,
  input wire logic [5:0] edges,
  input wire logic [3:0] gap,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [5:0] left_reg;
  logic [3:0] wait_reg;
  assign busy = go || left_reg != 6'h00;
  // ========
  // Toggles the pin every gap plus one cycles.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left_reg <= 6'h00;
      wait_reg <= 4'h0;
      pin <= 1'b0;
    end else if (go) begin
      left_reg <= edges;
      wait_reg <= gap;
    end else if (left_reg != 6'h00) begin
      if (wait_reg == 4'h0) begin
        pin <= !pin;
        left_reg <= left_reg - 6'h01;
        wait_reg <= gap;
      end else begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule

//--- icu_capture_bench.sv
`timescale 1ns/1ns
module icu_capture_bench;
  import icu_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0, sync_ev = 32'h0, rd, prev, r, prdata;
  logic pready, pslverr, pin, busy, casc, run, irq, wake, serr;
  logic go = 1'b0, low_power = 1'b0, peer_ce = 1'b0;
  logic [7:0] ticks = 8'h80;
  logic [5:0] edges = 6'h00;
  logic [3:0] gap = 4'h3;
  logic [2:0] modes [5] = '{ICU_RISE, ICU_FALL, ICU_BOTH, ICU_RISE4, ICU_RISE16};
  int lens [5] = '{8, 8, 4, 8, 32};
  integer seed = 32'h6E3E;
  int err_total = 0, tests_run = 0, cycles = 0, irqs = 0, wakes = 0, base, n;
  icu_capture dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_input_pin(pin), .time_base_ticks(ticks),
    .sync_events(sync_ev), .sync_source_enabled(1'b1), .low_power(low_power),
    .is_high_channel(1'b0), .peer_cascade_enable(peer_ce), .peer_wrap(1'b0),
    .peer_run(1'b0), .cascade_enable(casc), .wrap_out(), .run_out(run),
    .capture_irq(irq), .wake_irq(wake));
  icu_pulse_src u_src (.clock(clock), .rstn(rstn), .go(go), .edges(edges), .gap(gap),
    .pin(pin), .busy(busy));
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (irq) irqs <= irqs + 1;
    if (wake) wakes <= wakes + 1;
    if (cycles == 20000) test_done(1'b1);
  end
  task automatic test_done(input logic hang);
    if (hang) err_total = err_total + 1;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cnt_diff(input logic [15:0] exp);
    apb(1'b0, ICU_OFF_CNT, 32'h0);
    prev = rd;
    apb(1'b0, ICU_OFF_CNT, 32'h0);
    chk("count step", rd[15:0] - prev[15:0], exp);
  endtask
  task automatic train(input logic [5:0] cnt);
    r = $random(seed);
    edges <= cnt;
    gap <= 4'h2 + r[2:0];
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    while (busy) apb(1'b0, ICU_OFF_CON1, 32'h0);
    repeat (3) apb(1'b0, ICU_OFF_CON1, 32'h0);
  endtask
  task automatic drain(input int cnt, input logic [15:0] step);
    for (int k = 0; k < cnt; k++) begin
      apb(1'b0, ICU_OFF_CON1, 32'h0);
      chk("not empty", rd[ICU_C1_BNE], 32'h1);
      apb(1'b0, ICU_OFF_FIFO, 32'h0);
      if (k > 0 && step != 16'h0) chk("capture gap", rd[15:0] - prev[15:0], step);
      prev = rd;
    end
    apb(1'b0, ICU_OFF_CON1, 32'h0);
    chk("empty", rd[ICU_C1_BNE], 32'h0);
  endtask
  function automatic logic [15:0] step_of(logic [2:0] m);
    if (m == ICU_BOTH) return 16'(gap) + 16'h1;
    return (m == ICU_RISE4 || m == ICU_RISE16) ? 16'h0 : 16'(gap) * 16'h2 + 16'h2;
  endfunction
  function automatic int caps_of(logic [2:0] m, int e);
    case (m)
      ICU_BOTH: return e;
      ICU_RISE4: return e / 8;
      ICU_RISE16: return e / 32;
      default: return e / 2;
    endcase
  endfunction
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    apb(1'b0, ICU_OFF_CON1, 32'h0);
    chk("con1 reset", rd, 32'h0);
    apb(1'b0, ICU_OFF_CON2, 32'h0);
    chk("con2 reset", rd, {16'h0, ICU_C2_RESET});
    apb(1'b0, 4'h6, 32'h0);
    chk("misaligned", serr, 32'h1);
    apb(1'b1, ICU_OFF_CON2, 32'h0);
    for (int t = 0; t < 8; t++) begin
      if (t == 5 || t == 6) continue;
      apb(1'b1, ICU_OFF_CON1, {t[2:0], 7'h00, ICU_RISE});
      ticks <= 8'h01 << t;
      cnt_diff(16'h3);
      ticks <= ~(8'h01 << t);
      cnt_diff(16'h0);
    end
    ticks <= 8'h80;
    for (int i = 0; i < 5; i++) begin
      n = caps_of(modes[i], lens[i]);
      apb(1'b1, ICU_OFF_CON1, 32'h0);
      apb(1'b1, ICU_OFF_CON1, {ICU_TSEL_SYS, 3'h0, i[1:0], 2'h0, modes[i]});
      base = irqs;
      train(6'(lens[i]));
      chk("irq count", irqs - base, modes[i] == ICU_BOTH ? n : n / (i % 4 + 1));
      drain(n, step_of(modes[i]));
    end
    apb(1'b1, ICU_OFF_CON1, {ICU_TSEL_SYS, 10'h003});
    train(6'd12);
    apb(1'b0, ICU_OFF_CON1, 32'h0);
    chk("overflow", rd[ICU_C1_OV], 32'h1);
    apb(1'b1, ICU_OFF_CON1, {ICU_TSEL_SYS, 10'h003});
    apb(1'b0, ICU_OFF_CON1, 32'h0);
    chk("overflow kept", rd[ICU_C1_OV], 32'h1);
    drain(4, step_of(ICU_RISE));
    chk("overflow cleared", rd[ICU_C1_OV], 32'h0);
    apb(1'b1, ICU_OFF_CON1, 32'hFFFF);
    apb(1'b0, ICU_OFF_CON1, 32'h0);
    chk("con1 mask", rd, {16'h0, ICU_C1_WMASK});
    low_power <= 1'b1;
    base = wakes;
    train(6'd2);
    chk("wake", wakes - base, 32'h1);
    chk("no capture", rd[ICU_C1_BNE], 32'h0);
    low_power <= 1'b0;
    peer_ce <= 1'b1;
    // Pair shares time base and source.
    // Low word channel reads its own buffer.
    apb(1'b1, ICU_OFF_CON2, 32'hFFFF);
    apb(1'b0, ICU_OFF_CON2, 32'h0);
    chk("con2 mask", rd, {16'h0, ICU_C2_WMASK});
    chk("cascade", casc, 32'h1);
    apb(1'b1, ICU_OFF_CON1, {ICU_TSEL_SYS, 10'h003});
    apb(1'b1, ICU_OFF_CON2, 32'h000B);
    chk("cascade off", casc, 32'h0);
    sync_ev <= 32'h800;
    @(posedge clock);
    sync_ev <= 32'h0;
    apb(1'b0, ICU_OFF_CNT, 32'h0);
    chk("sync clear", rd[15:0] < 16'h8, 32'h1);
    apb(1'b1, ICU_OFF_CON2, 32'h008B);
    apb(1'b0, ICU_OFF_CON2, 32'h0);
    cnt_diff(16'h0);
    sync_ev <= 32'h800;
    @(posedge clock);
    sync_ev <= 32'h0;
    apb(1'b0, ICU_OFF_CON2, 32'h0);
    chk("triggered", rd[ICU_C2_TSTAT], 32'h1);
    cnt_diff(16'h3);
    apb(1'b1, ICU_OFF_CON2, 32'h0080);
    cnt_diff(16'h0);
    apb(1'b1, ICU_OFF_CON2, 32'h00C0);
    cnt_diff(16'h3);
    test_done(1'b0);
  end
endmodule
